// file: tis_params.svh
// register map, reset values and field positions for the threshold block
`ifndef TIS_PARAMS_SVH
`define TIS_PARAMS_SVH
`define TIS_ADDR_LOW_UP    8'h8A
`define TIS_ADDR_LOW_LO    8'h8B
`define TIS_ADDR_HIGH_UP   8'h8C
`define TIS_ADDR_HIGH_LO   8'h8D
`define TIS_ADDR_FLAGS     8'h8E
`define TIS_ADDR_MODTIM    8'h8F
`define TIS_ADDR_AMB_IR    8'h90
`define TIS_MODTIM_RESET   8'h01
`define TIS_LIMIT_RESET    16'h0000
`define TIS_FLAGS_RESET    4'h0
`define TIS_BIT_HIGH       0
`define TIS_BIT_LOW        1
`define TIS_BIT_ALS        2
`define TIS_BIT_PROX       3
`define TIS_DELAY_MSB      7
`define TIS_DELAY_LSB      5
`define TIS_FREQ_MSB       4
`define TIS_FREQ_LSB       3
`define TIS_DEAD_MSB       2
`define TIS_DEAD_LSB       0
`endif

// file: tis_pkg.sv
// types shared by the threshold and interrupt status block
`default_nettype none
package tis_pkg;
  typedef logic [7:0]  tis_byte_t;   // one register byte
  typedef logic [15:0] tis_word_t;   // one measurement or limit
  typedef enum logic [0:0] {TIS_STANDBY, TIS_MEASURE} tis_pwr_t;
endpackage
`default_nettype wire

// file: tis_cmp.sv
// limit comparator for one completed result
`default_nettype none
module tis_cmp #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] value,
  input  wire logic [WIDTH-1:0] high_limit,
  input  wire logic [WIDTH-1:0] low_limit,
  output logic                  above_high,
  output logic                  below_low
);
  // strict comparisons against each limit
  assign above_high = value > high_limit;
  assign below_low  = value < low_limit;
endmodule
`default_nettype wire

// file: tis_top.sv
// threshold registers, sticky event flags and interrupt pin
`include "tis_params.svh"
`default_nettype none
module tis_top (
  input  wire logic             ref_clk,      // block clock
  input  wire logic             srst,         // sync reset, high
  input  wire logic             clk_en,       // freezes state when low
  input  wire logic             reg_wr,       // register write strobe
  input  wire logic             reg_rd,       // register read strobe
  input  wire logic [7:0]       reg_addr,     // register address
  input  wire tis_pkg::tis_byte_t reg_wdata,  // write data
  output tis_pkg::tis_byte_t    reg_rdata,    // read data, registered
  input  wire logic             meas_req,     // measurement demanded
  input  wire logic             prox_done,    // proximity result ready
  input  wire logic             als_done,     // ambient result ready
  input  wire tis_pkg::tis_word_t prox_value, // proximity result
  input  wire tis_pkg::tis_word_t als_value,  // ambient result
  input  wire logic             prox_rdy_en,  // proximity ready irq enable
  input  wire logic             als_rdy_en,   // ambient ready irq enable
  input  wire logic             thresh_en,    // limit irq enable
  input  wire logic             thresh_sel_als, // 1: limits on ambient
  output logic                  int_n,        // interrupt pin, low active
  output logic                  emitter_en,   // emitter sink enable
  output logic                  standby,      // standby indication
  output logic [2:0]            mod_delay,    // modulation delay field
  output logic [1:0]            prox_freq,    // proximity frequency
  output logic [2:0]            mod_dead      // modulation dead time
);
  import tis_pkg::*;

  tis_word_t high_limit_q;   // high limit value
  tis_word_t low_limit_q;    // low limit value
  logic [3:0] flags_q;       // sticky event flags
  tis_byte_t modtim_q;       // modulator timing register
  tis_pwr_t  pwr_q;          // power state
  logic      above_high;     // comparator output
  logic      below_low;      // comparator output
  logic      sel_done;       // selected function completed
  tis_word_t sel_value;      // selected result
  logic [3:0] set_vec;       // events this cycle
  logic [3:0] clr_vec;       // host clears this cycle

  // pick the function the limits apply to
  assign sel_done  = thresh_sel_als ? als_done : prox_done;
  assign sel_value = thresh_sel_als ? als_value : prox_value;

  tis_cmp #(.WIDTH(16)) u_cmp (
    .value      (sel_value),
    .high_limit (high_limit_q),
    .low_limit  (low_limit_q),
    .above_high (above_high),
    .below_low  (below_low)
  );

  // limit registers, byte written individually
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      high_limit_q <= `TIS_LIMIT_RESET;
      low_limit_q  <= `TIS_LIMIT_RESET;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        `TIS_ADDR_HIGH_UP: high_limit_q[15:8] <= reg_wdata;
        `TIS_ADDR_HIGH_LO: high_limit_q[7:0]  <= reg_wdata;
        `TIS_ADDR_LOW_UP:  low_limit_q[15:8]  <= reg_wdata;
        `TIS_ADDR_LOW_LO:  low_limit_q[7:0]   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // event sources, each gated by its enable
  always_comb
  begin
    set_vec = '0;
    set_vec[`TIS_BIT_PROX] = prox_done && prox_rdy_en;
    set_vec[`TIS_BIT_ALS]  = als_done && als_rdy_en;
    set_vec[`TIS_BIT_LOW]  = sel_done && thresh_en && below_low;
    set_vec[`TIS_BIT_HIGH] = sel_done && thresh_en && above_high;
  end

  // host write of one clears that flag
  assign clr_vec = (reg_wr && reg_addr == `TIS_ADDR_FLAGS)
                   ? reg_wdata[3:0] : 4'h0;

  // sticky flags; a new event wins over a clear
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      flags_q <= `TIS_FLAGS_RESET;
    else if (clk_en)
      flags_q <= (flags_q & ~clr_vec) | set_vec;
  end

  // modulator timing register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      modtim_q <= `TIS_MODTIM_RESET;
    else if (clk_en && reg_wr && reg_addr == `TIS_ADDR_MODTIM)
      modtim_q <= reg_wdata;
  end

  assign mod_delay = modtim_q[`TIS_DELAY_MSB:`TIS_DELAY_LSB];
  assign prox_freq = modtim_q[`TIS_FREQ_MSB:`TIS_FREQ_LSB];
  assign mod_dead  = modtim_q[`TIS_DEAD_MSB:`TIS_DEAD_LSB];

  // power state follows measurement demand
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pwr_q <= TIS_STANDBY;
    else if (clk_en)
    begin
      case (pwr_q)
        TIS_STANDBY: if (meas_req) pwr_q <= TIS_MEASURE;
        TIS_MEASURE: if (!meas_req) pwr_q <= TIS_STANDBY;
        default: pwr_q <= TIS_STANDBY;
      endcase
    end
  end

  assign standby    = (pwr_q == TIS_STANDBY);
  assign emitter_en = (pwr_q == TIS_MEASURE);
  assign int_n      = ~(|flags_q);

  // registered read data; reserved and unmapped read zero
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
    begin
      case (reg_addr)
        `TIS_ADDR_HIGH_UP: reg_rdata <= high_limit_q[15:8];
        `TIS_ADDR_HIGH_LO: reg_rdata <= high_limit_q[7:0];
        `TIS_ADDR_LOW_UP:  reg_rdata <= low_limit_q[15:8];
        `TIS_ADDR_LOW_LO:  reg_rdata <= low_limit_q[7:0];
        `TIS_ADDR_FLAGS:   reg_rdata <= {4'h0, flags_q};
        `TIS_ADDR_MODTIM:  reg_rdata <= modtim_q;
        default:           reg_rdata <= 8'h00; // 90h reserved
      endcase
    end
  end

  // checks
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && flags_q[0] && !clr_vec[0] |=> flags_q[0])
    else $error("flag dropped without clear");
  flag_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && prox_done && prox_rdy_en |=> flags_q[3])
    else $error("proximity flag not set");
  high_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && sel_done && thresh_en && sel_value > high_limit_q
    |=> flags_q[0])
    else $error("high flag not set");
  low_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && sel_done && thresh_en && sel_value < low_limit_q
    |=> flags_q[1])
    else $error("low flag not set");
  no_enable_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && !flags_q[3] && !(prox_done && prox_rdy_en)
    |=> !flags_q[3])
    else $error("proximity flag without enable");
  int_pin_a: assert property (@(posedge ref_clk) disable iff (srst)
    int_n == (flags_q == 4'h0))
    else $error("interrupt pin mismatch");
  clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && clr_vec[2] && !set_vec[2] |=> !flags_q[2])
    else $error("flag not cleared");
  standby_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && !meas_req |=> standby && !emitter_en)
    else $error("not in standby");
  modtim_a: assert property (@(posedge ref_clk)
    srst |=> modtim_q == `TIS_MODTIM_RESET)
    else $error("timing reset wrong");

  // upper byte of the high limit takes the written byte
  high_up_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == `TIS_ADDR_HIGH_UP
    |=> high_limit_q[15:8] == $past(reg_wdata))
    else $error("high limit upper byte not written");
  // lower byte of the high limit takes the written byte
  high_lo_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == `TIS_ADDR_HIGH_LO
    |=> high_limit_q[7:0] == $past(reg_wdata))
    else $error("high limit lower byte not written");
  // upper byte of the low limit takes the written byte
  low_up_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == `TIS_ADDR_LOW_UP
    |=> low_limit_q[15:8] == $past(reg_wdata))
    else $error("low limit upper byte not written");
  // lower byte of the low limit takes the written byte
  low_lo_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == `TIS_ADDR_LOW_LO
    |=> low_limit_q[7:0] == $past(reg_wdata))
    else $error("low limit lower byte not written");
  // ambient ready with its enable sets its flag
  als_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && als_done && als_rdy_en |=> flags_q[2])
    else $error("ambient flag not set");
  // no high flag appears while limit events are disabled
  high_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && !thresh_en && !flags_q[0] |=> !flags_q[0])
    else $error("high flag without enable");
  // no low flag appears while limit events are disabled
  low_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && !thresh_en && !flags_q[1] |=> !flags_q[1])
    else $error("low flag without enable");
  // flags hold while the clock enable is low
  flag_freeze_a: assert property (@(posedge ref_clk) disable iff (srst)
    !clk_en |=> $stable(flags_q))
    else $error("flags moved while frozen");
  // read data stands until the next read
  rdata_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without read");
  // a flag read returns the flags with upper bits zero
  flags_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == `TIS_ADDR_FLAGS
    |=> reg_rdata == {4'h0, $past(flags_q)})
    else $error("flag read wrong");
  // the reserved level register reads zero
  reserved_rd_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == `TIS_ADDR_AMB_IR
    |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  // a measurement demand leaves standby and enables the sink
  measure_a: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && meas_req |=> !standby && emitter_en)
    else $error("not measuring");
endmodule
`default_nettype wire

// file: tis_host.sv
// host side model: drives register writes and reads on the block
`default_nettype none
module tis_host (
  input  wire logic          ref_clk,
  input  wire tis_pkg::tis_byte_t reg_rdata,
  output logic               reg_wr,
  output logic               reg_rd,
  output logic [7:0]         reg_addr,
  output tis_pkg::tis_byte_t reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import tis_pkg::*;
  // idle bus at time zero; address 90h is never issued
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // one write; a one written to a flag bit clears it
  task automatic wr(input logic [7:0] a, input tis_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read; data is taken 1 ns after the edge that samples the read
  task automatic rd(input logic [7:0] a, output tis_byte_t d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the threshold and event flag block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tis_pkg::*;
  logic       ref_clk, srst, meas_req, prox_done, als_done, clk_en;
  logic       prox_rdy_en, als_rdy_en, thresh_en, thresh_sel_als;
  logic       reg_wr, reg_rd, int_n, emitter_en, standby;
  logic [7:0] reg_addr;
  tis_byte_t  reg_wdata, reg_rdata, rd;
  tis_word_t  prox_value, als_value;
  logic [2:0] mod_delay, mod_dead;
  logic [1:0] prox_freq;
  int         n_fail, checked, seed, i, hi, lo, fl, v, m, e;
  tis_top u_dut (.ref_clk, .srst, .clk_en, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .meas_req, .prox_done, .als_done,
    .prox_value, .als_value, .prox_rdy_en, .als_rdy_en, .thresh_en,
    .thresh_sel_als, .int_n, .emitter_en, .standby, .mod_delay,
    .prox_freq, .mod_dead);
  tis_host u_host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string s, input logic [15:0] x, g);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input int x, input string s);
    u_host.rd(a, rd);
    chk(s, 16'(x), {8'h00, rd});
  endtask
  // one random result; model flags from enables and limits
  task automatic ev;
    e = $random(seed);
    v = $random(seed) & 16'hFFFF;
    @(posedge ref_clk);
    {prox_rdy_en, als_rdy_en, thresh_en, thresh_sel_als} <= e[3:0];
    prox_value <= 16'(v);
    als_value <= 16'(v);
    if (e[4]) als_done <= 1'b1;
    else prox_done <= 1'b1;
    if (e[4] && e[2]) fl |= 4;
    if (!e[4] && e[3]) fl |= 8;
    if (e[1] && e[0] == e[4] && v > hi) fl |= 1;
    if (e[1] && e[0] == e[4] && v < lo) fl |= 2;
    @(posedge ref_clk);
    {prox_done, als_done} <= 2'b00;
    #1 chk("int_n", 16'(fl == 0), int_n);
    rdc(8'h8E, fl, "flags");
    m = $random(seed) & 8'hFF;
    u_host.wr(8'h8E, m[7:0]);
    fl &= ~m;
    rdc(8'h8E, fl, "flags_clr");
  endtask
  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    seed = 38026;
    {n_fail, checked, fl} = '0;
    {srst, meas_req, prox_done, als_done} = 4'b1000;
    clk_en = 1'b1;
    {prox_rdy_en, als_rdy_en, thresh_en, thresh_sel_als} = 4'h0;
    {prox_value, als_value} = '0;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    #1 chk("int_n", 1, int_n);
    chk("standby", 1, standby);
    chk("dead", 1, mod_dead);
    chk("delay", 0, mod_delay);
    rdc(8'h8F, 1, "timing");
    $display("test reset done");
    hi = $random(seed) & 16'hFFFF;
    lo = $random(seed) & 16'hFFFF;
    u_host.wr(8'h8C, hi[15:8]);
    u_host.wr(8'h8D, hi[7:0]);
    u_host.wr(8'h8A, lo[15:8]);
    u_host.wr(8'h8B, lo[7:0]);
    rdc(8'h8C, hi >> 8, "hi_up");
    rdc(8'h8D, hi & 255, "hi_lo");
    rdc(8'h8A, lo >> 8, "lo_up");
    rdc(8'h8B, lo & 255, "lo_lo");
    rdc(8'h91, 0, "unmapped");
    // a write while the clock enable is low must not land
    @(posedge ref_clk);
    clk_en <= 1'b0;
    u_host.wr(8'h8C, ~hi[15:8]);
    clk_en <= 1'b1;
    rdc(8'h8C, hi >> 8, "hi_frozen");
    $display("test limits done");
    for (i = 0; i < 60; i++) ev();
    $display("test events done");
    m = $random(seed) & 8'hFF;
    u_host.wr(8'h8F, m[7:0]);
    #1 chk("delay", 16'(m[7:5]), mod_delay);
    chk("freq", 16'(m[4:3]), prox_freq);
    chk("dead", 16'(m[2:0]), mod_dead);
    u_host.wr(8'h8F, 8'h01);
    rdc(8'h8F, 1, "timing");
    @(posedge ref_clk);
    meas_req <= 1'b1;
    @(posedge ref_clk);
    #1 chk("standby", 0, standby);
    chk("emitter", 1, emitter_en);
    @(posedge ref_clk);
    meas_req <= 1'b0;
    @(posedge ref_clk);
    #1 chk("standby", 1, standby);
    chk("emitter", 0, emitter_en);
    $display("test timing and standby done");
    end_sim();
  end
endmodule
`default_nettype wire
